// ### design/acci2c_ctrl.sv
// Two-wire bus controller end: register writes and burst reads.
// Makes the bus clock from clk by a divider; no clock stretching expected.
`timescale 1ns/10ps
module acci2c_ctrl #(
   parameter int LEN_W = acci2c_pkg::LEN_W_DEF // Width of byte count
) (
   input wire logic clk, // System clock, 10 MHz
   input wire logic sys_rst, // Synchronous reset, active high
   input wire logic clkEn, // Freezes all state while low
   input wire logic fastMode, // Fast rate instead of standard
   input wire logic cmdValid, // Command request
   output logic cmdReady, // Idle, command accepted
   input wire logic cmdRead, // Read instead of write
   input wire logic cmdSplitStop, // Stop then start before read phase
   input wire logic [6:0] cmdDevAddr, // Target bus address
   input wire logic [7:0] cmdRegAddr, // First register
   input wire logic [LEN_W-1:0] cmdLen, // Data bytes, at least one
   input wire logic [7:0] wrData, // Next write byte
   output logic wrTake, // Pulse, wrData consumed
   output logic [7:0] rdData, // Last read byte
   output logic rdValid, // Pulse, rdData new
   output logic done, // Pulse, transfer finished
   output logic nackErr, // Last transfer saw a nack
   acci2c_if.ctrl bus // Two-wire bus pins
);
   import acci2c_pkg::*;

   if (LEN_W < 1 || LEN_W > 16) begin : g_len_check
      $error("LEN_W must be 1 to 16");
   end

   acci2c_ctrl_state_e stateReg;
   logic [QTR_W-1:0] qcntReg;
   logic [1:0] qphReg;
   logic [3:0] bitIdxReg;
   logic [7:0] txByteReg;
   logic [7:0] rxByteReg;
   logic [LEN_W-1:0] remainReg;
   logic readReg;
   logic splitReg;
   logic fastReg;
   logic pendReadReg;
   logic ackOkReg;
   logic [6:0] devAddrReg;
   logic [7:0] regAddrReg;
   logic sclOeReg;
   logic sdaOeReg;
   logic sda1Reg;
   logic sda2Reg;
   logic tick;
   logic txState;
   logic sclWant;
   logic sdaWant;
   logic lastByte;

   // Bus data comes from another domain
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         sda1Reg <= 1'b1;
         sda2Reg <= 1'b1;
      end else if (clkEn) begin
         sda1Reg <= bus.sda;
         sda2Reg <= sda1Reg;
      end
   end

   // Quarter-period divider; rate bounded by rounding up
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         qcntReg <= '0;
      end else if (clkEn) begin
         if (stateReg == C_IDLE) begin
            // Preload so a frame opens with a full quarter
            qcntReg <= (fastMode ? QTR_FAST_CYC : QTR_STD_CYC) - QTR_W'(1);
         end else if (qcntReg == '0) begin
            qcntReg <= (fastReg ? QTR_FAST_CYC : QTR_STD_CYC) - QTR_W'(1);
         end else begin
            qcntReg <= qcntReg - QTR_W'(1);
         end
      end
   end

   assign tick = (stateReg != C_IDLE) && (qcntReg == '0);
   assign txState = (stateReg == C_ADDRW) || (stateReg == C_REGA) ||
      (stateReg == C_WDATA) || (stateReg == C_ADDRR);
   assign lastByte = (remainReg == LEN_W'(1));

   // Line wants per phase; clock low in phases 0 and 1
   always_comb begin
      sclWant = 1'b0;
      sdaWant = 1'b0;
      case (stateReg)
         C_IDLE: begin
            sclWant = 1'b0;
            sdaWant = 1'b0;
         end
         C_START: begin
            sclWant = (qphReg < 2'd2);
            sdaWant = (qphReg == 2'd3);
         end
         C_STOP: begin
            sclWant = (qphReg < 2'd2);
            sdaWant = (qphReg != 2'd3);
         end
         default: begin
            sclWant = (qphReg < 2'd2);
            if (bitIdxReg < 4'(BYTE_BITS)) begin
               sdaWant = txState && !txByteReg[3'(4'd7 - bitIdxReg)];
            end else begin
               // Ack all read bytes but the last, which gets a nack
               sdaWant = (stateReg == C_RDATA) && !lastByte;
            end
         end
      endcase
   end

   // Data bits move in phase 1, a quarter after clock falls; start and stop move data in phase 3
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         sclOeReg <= 1'b0;
         sdaOeReg <= 1'b0;
      end else if (clkEn) begin
         sclOeReg <= sclWant;
         if (stateReg == C_IDLE || qphReg != 2'd0) begin
            sdaOeReg <= sdaWant;
         end
      end
   end

   // Transfer sequencing
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         stateReg <= C_IDLE;
         qphReg <= 2'd0;
         bitIdxReg <= 4'h0;
         txByteReg <= 8'h00;
         rxByteReg <= 8'h00;
         remainReg <= '0;
         readReg <= 1'b0;
         splitReg <= 1'b0;
         fastReg <= 1'b0;
         pendReadReg <= 1'b0;
         ackOkReg <= 1'b0;
         devAddrReg <= 7'h00;
         regAddrReg <= 8'h00;
         wrTake <= 1'b0;
         rdValid <= 1'b0;
         done <= 1'b0;
         nackErr <= 1'b0;
         rdData <= 8'h00;
      end else if (clkEn) begin
         wrTake <= 1'b0;
         rdValid <= 1'b0;
         done <= 1'b0;
         if (stateReg == C_IDLE) begin
            if (cmdValid) begin
               stateReg <= C_START;
               qphReg <= 2'd0;
               readReg <= cmdRead;
               splitReg <= cmdSplitStop;
               fastReg <= fastMode;
               devAddrReg <= cmdDevAddr;
               regAddrReg <= cmdRegAddr;
               remainReg <= cmdLen;
               pendReadReg <= 1'b0;
               nackErr <= 1'b0;
            end
         end else if (tick) begin
            qphReg <= qphReg + 2'd1;
            if (qphReg == 2'd2) begin
               if (bitIdxReg < 4'(BYTE_BITS)) begin
                  rxByteReg <= {rxByteReg[6:0], sda2Reg};
               end else begin
                  ackOkReg <= !sda2Reg;
               end
            end
            if (qphReg == 2'd3) begin
               bitIdxReg <= 4'h0;
               case (stateReg)
                  C_START: begin
                     stateReg <= pendReadReg ? C_ADDRR : C_ADDRW;
                     txByteReg <= {devAddrReg, pendReadReg};
                     pendReadReg <= 1'b0;
                  end
                  C_STOP: begin
                     if (pendReadReg) begin
                        stateReg <= C_START;
                     end else begin
                        stateReg <= C_IDLE;
                        done <= 1'b1;
                     end
                  end
                  default: begin
                     if (bitIdxReg != 4'(BYTE_BITS)) begin
                        bitIdxReg <= bitIdxReg + 4'h1;
                     end else if (stateReg != C_RDATA && !ackOkReg) begin
                        nackErr <= 1'b1;
                        stateReg <= C_STOP;
                     end else if (stateReg == C_ADDRW) begin
                        txByteReg <= regAddrReg;
                        stateReg <= C_REGA;
                     end else if (stateReg == C_REGA && readReg) begin
                        pendReadReg <= 1'b1;
                        stateReg <= splitReg ? C_STOP : C_START;
                     end else if (stateReg == C_REGA ||
                        (stateReg == C_WDATA && !lastByte)) begin
                        if (stateReg == C_WDATA) begin
                           remainReg <= remainReg - LEN_W'(1);
                        end
                        txByteReg <= wrData;
                        wrTake <= 1'b1;
                        stateReg <= C_WDATA;
                     end else if (stateReg == C_ADDRR) begin
                        stateReg <= C_RDATA;
                     end else if (stateReg == C_RDATA) begin
                        rdData <= rxByteReg;
                        rdValid <= 1'b1;
                        remainReg <= remainReg - LEN_W'(1);
                        stateReg <= lastByte ? C_STOP : C_RDATA;
                     end else begin
                        stateReg <= C_STOP;
                     end
                  end
               endcase
            end
         end
      end
   end

   assign cmdReady = (stateReg == C_IDLE);
   assign bus.sclCtrlOut = 1'b0;
   assign bus.sclCtrlOe = sclOeReg;
   assign bus.sdaCtrlOut = 1'b0;
   assign bus.sdaCtrlOe = sdaOeReg;
endmodule // acci2c_ctrl

// ### common/acci2c_pkg.sv
// Shared constants and state types for the two-wire accelerometer port.
// Assumes the controller clock runs at 10 MHz; the target samples the bus on its own link clock.
package acci2c_pkg;
   localparam int DATA_W = 8;
   localparam int BYTE_BITS = 8;
   localparam int LEN_W_DEF = 8;
   // Bus addresses for the two strap levels
   localparam logic [6:0] ADDR_STRAP_HIGH = 7'h1d;
   localparam logic [6:0] ADDR_STRAP_LOW = 7'h53;
   // Synchroniser reset value {select, strap, clock, data}: bus lines idle high
   localparam logic [3:0] SYNC_RST = 4'h3;
   localparam logic [7:0] PTR_RST = 8'h00;
   // Field positions inside the synchroniser word
   localparam int SYNC_SEL = 3;
   localparam int SYNC_STRAP = 2;
   localparam int SYNC_SCL = 1;
   localparam int SYNC_SDA = 0;
   // Bus clock timing, controller side
   localparam int CLK_PERIOD_NS = 100;
   localparam int STD_RATE_KHZ = 100;
   localparam int FAST_RATE_KHZ = 400;
   localparam int QTR_STD_NS = 1000000 / (STD_RATE_KHZ * 4);
   localparam int QTR_FAST_NS = 1000000 / (FAST_RATE_KHZ * 4);
   localparam int QTR_W = 5;
   // Quarter periods round up so the bus clock never exceeds its rate
   localparam logic [QTR_W-1:0] QTR_STD_CYC =
      QTR_W'((QTR_STD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [QTR_W-1:0] QTR_FAST_CYC =
      QTR_W'((QTR_FAST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   typedef enum logic [2:0] {
      D_IDLE = 3'b000,
      D_ADDR = 3'b001,
      D_RX = 3'b010,
      D_ACK = 3'b011,
      D_TX = 3'b100,
      D_TXACK = 3'b101,
      D_IGNORE = 3'b110
   } acci2c_dev_state_e;
   typedef enum logic [2:0] {
      C_IDLE = 3'b000,
      C_START = 3'b001,
      C_ADDRW = 3'b010,
      C_REGA = 3'b011,
      C_WDATA = 3'b100,
      C_ADDRR = 3'b101,
      C_RDATA = 3'b110,
      C_STOP = 3'b111
   } acci2c_ctrl_state_e;
endpackage

// ### common/acci2c_if.sv
// Two-wire bus between the controller and the accelerometer target.
// Both lines are open drain with pull-ups; the wire level is resolved here.
`timescale 1ns/10ps
interface acci2c_if;
   logic sclCtrlOut;
   logic sclCtrlOe;
   logic sdaCtrlOut;
   logic sdaCtrlOe;
   logic sdaDevOut;
   logic sdaDevOe;
   logic scl;
   logic sda;
   // Pull-up wins unless a driver enables a low
   assign scl = !(sclCtrlOe && !sclCtrlOut);
   assign sda = !((sdaCtrlOe && !sdaCtrlOut) || (sdaDevOe && !sdaDevOut));
   modport ctrl (
      input scl,
      input sda,
      output sclCtrlOut,
      output sclCtrlOe,
      output sdaCtrlOut,
      output sdaCtrlOe
   );
   modport dev (
      input scl,
      input sda,
      output sdaDevOut,
      output sdaDevOe
   );
endinterface

// ### design/acci2c_target.sv
// Two-wire bus target of the accelerometer, byte-wide register access.
// Runs entirely on the link clock; the register file beyond it answers
// combinationally on regRdData for the address on regPtr.
`timescale 1ns/10ps
// Function
// - Two-wire target only while chip select high
// - Strap high answers address 0x1D
// - Strap low answers address 0x53
// - Standard and fast rates; controller limits
// - Write: address, register, data; ack each
// - Single read ends with controller nack, stop
// - Burst read continues while controller acks
// - Repeated start or stop-start before read
module acci2c_target (
   input wire logic linkClk, // Link clock, samples the bus
   input wire logic sys_rst, // Synchronous reset, active high
   input wire logic clkEn, // Freezes all state but the reset synchroniser while low
   acci2c_if.dev bus, // Two-wire bus pins
   input wire logic chipSelect, // Pin, high selects two-wire mode
   input wire logic busAddressStrap, // Pin, picks bus address
   output logic [acci2c_pkg::DATA_W-1:0] regPtr, // Current register pointer
   input wire logic [acci2c_pkg::DATA_W-1:0] regRdData, // Read data at regPtr
   output logic regWrite, // Pulse, write strobe
   output logic regRead, // Pulse, read byte taken
   output logic [acci2c_pkg::DATA_W-1:0] regAddr, // Address of the strobe
   output logic [acci2c_pkg::DATA_W-1:0] regWrData, // Write data of the strobe
   output logic busActive // Transfer addressed or in progress
);
   import acci2c_pkg::*;

   logic [3:0] sync1Reg;
   logic [3:0] sync2Reg;
   logic prevSclReg;
   logic prevSdaReg;
   logic sclNow;
   logic sdaNow;
   logic selNow;
   logic strapNow;
   logic startSeen;
   logic stopSeen;
   logic sclRise;
   logic sclFall;
   logic [6:0] ownAddr;
   acci2c_dev_state_e stateReg;
   logic [3:0] cntReg;
   logic [DATA_W-1:0] shiftReg;
   logic [DATA_W-1:0] ptrReg;
   logic readDirReg;
   logic regPhaseReg;
   logic masterAckReg;
   logic sdaOeReg;
   logic loadTx;
   logic rstMetaReg;
   logic rstLinkReg;

   // Reset comes from the other clock; two flops before use
   always_ff @(posedge linkClk) begin
      rstMetaReg <= sys_rst;
      rstLinkReg <= rstMetaReg;
   end

   // Pins pass two flops; only the second stage is looked at
   always_ff @(posedge linkClk) begin
      if (rstLinkReg) begin
         sync1Reg <= SYNC_RST;
         sync2Reg <= SYNC_RST;
      end else if (clkEn) begin
         sync1Reg <= {chipSelect, busAddressStrap, bus.scl, bus.sda};
         sync2Reg <= sync1Reg;
      end
   end

   // Previous samples for edge and condition detection
   always_ff @(posedge linkClk) begin
      if (rstLinkReg) begin
         prevSclReg <= 1'b1;
         prevSdaReg <= 1'b1;
      end else if (clkEn) begin
         prevSclReg <= sclNow;
         prevSdaReg <= sdaNow;
      end
   end

   assign sclNow = sync2Reg[SYNC_SCL];
   assign sdaNow = sync2Reg[SYNC_SDA];
   assign selNow = sync2Reg[SYNC_SEL];
   assign strapNow = sync2Reg[SYNC_STRAP];

   // Data moving while the clock stays high marks start or stop
   assign startSeen = sclNow && prevSclReg && prevSdaReg && !sdaNow;
   assign stopSeen = sclNow && prevSclReg && !prevSdaReg && sdaNow;
   assign sclRise = sclNow && !prevSclReg;
   assign sclFall = !sclNow && prevSclReg;

   // Strap picks the address; followed live, no latch
   assign ownAddr = strapNow ? ADDR_STRAP_HIGH : ADDR_STRAP_LOW;

   // A read byte is fetched after the address ack or a controller ack
   assign loadTx = (stateReg == D_ACK) ? readDirReg : masterAckReg;

   // Byte engine: shifts, acks and register strobes
   always_ff @(posedge linkClk) begin
      if (rstLinkReg) begin
         stateReg <= D_IDLE;
         cntReg <= 4'h0;
         shiftReg <= 8'h00;
         ptrReg <= PTR_RST;
         readDirReg <= 1'b0;
         regPhaseReg <= 1'b0;
         masterAckReg <= 1'b0;
         sdaOeReg <= 1'b0;
         regWrite <= 1'b0;
         regRead <= 1'b0;
         regAddr <= 8'h00;
         regWrData <= 8'h00;
      end else if (clkEn) begin
         regWrite <= 1'b0;
         regRead <= 1'b0;
         if (!selNow || stopSeen) begin
            // Deselected or stopped: release and wait
            stateReg <= D_IDLE;
            sdaOeReg <= 1'b0;
            cntReg <= 4'h0;
         end else if (startSeen) begin
            // Plain or repeated start both reopen addressing
            stateReg <= D_ADDR;
            sdaOeReg <= 1'b0;
            cntReg <= 4'h0;
         end else begin
            case (stateReg)
               D_ADDR, D_RX: begin
                  if (sclRise) begin
                     shiftReg <= {shiftReg[6:0], sdaNow};
                     cntReg <= cntReg + 4'h1;
                  end else if (sclFall && cntReg == 4'(BYTE_BITS)) begin
                     cntReg <= 4'h0;
                     if (stateReg == D_ADDR) begin
                        if (shiftReg[7:1] == ownAddr) begin
                           sdaOeReg <= 1'b1;
                           readDirReg <= shiftReg[0];
                           regPhaseReg <= !shiftReg[0];
                           stateReg <= D_ACK;
                        end else begin
                           // Not ours: line stays released till stop or a new start
                           stateReg <= D_IGNORE;
                        end
                     end else begin
                        sdaOeReg <= 1'b1;
                        stateReg <= D_ACK;
                        if (regPhaseReg) begin
                           ptrReg <= shiftReg;
                           regPhaseReg <= 1'b0;
                        end else begin
                           regWrite <= 1'b1;
                           regAddr <= ptrReg;
                           regWrData <= shiftReg;
                           ptrReg <= ptrReg + 8'h01;
                        end
                     end
                  end
               end
               D_ACK, D_TXACK: begin
                  if (sclRise) begin
                     cntReg <= 4'h1;
                     if (stateReg == D_TXACK) begin
                        masterAckReg <= !sdaNow;
                     end
                  end else if (sclFall && cntReg != 4'h0) begin
                     cntReg <= 4'h0;
                     if (loadTx) begin
                        // Fetch at the pointer, then advance it
                        shiftReg <= regRdData;
                        sdaOeReg <= !regRdData[7];
                        regRead <= 1'b1;
                        regAddr <= ptrReg;
                        ptrReg <= ptrReg + 8'h01;
                        stateReg <= D_TX;
                     end else if (stateReg == D_ACK) begin
                        sdaOeReg <= 1'b0;
                        stateReg <= D_RX;
                     end else begin
                        // Controller nack ends the read; wait for stop or a new start
                        sdaOeReg <= 1'b0;
                        stateReg <= D_IGNORE;
                     end
                  end
               end
               D_TX: begin
                  if (sclFall) begin
                     if (cntReg == 4'(BYTE_BITS - 1)) begin
                        sdaOeReg <= 1'b0;
                        cntReg <= 4'h0;
                        stateReg <= D_TXACK;
                     end else begin
                        shiftReg <= {shiftReg[6:0], 1'b0};
                        sdaOeReg <= !shiftReg[6];
                        cntReg <= cntReg + 4'h1;
                     end
                  end
               end
               D_IDLE, D_IGNORE: begin
                  sdaOeReg <= 1'b0;
               end
               default: begin
                  stateReg <= D_IDLE;
                  sdaOeReg <= 1'b0;
               end
            endcase
         end
      end
   end

   // Open drain: only ever pulls low, never drives high
   assign bus.sdaDevOut = 1'b0;
   assign bus.sdaDevOe = sdaOeReg;
   assign regPtr = ptrReg;
   assign busActive = (stateReg != D_IDLE) && (stateReg != D_IGNORE);
endmodule // acci2c_target

// ### verif/acci2c_asserts.sv
// Checker for the two-wire link between the two ends.
// Sees the interface lines as plain inputs; placed beside the interface.
`timescale 1ns/10ps
module acci2c_asserts (
   input wire logic clk, // Controller clock
   input wire logic linkClk, // Target clock
   input wire logic sys_rst, // Reset, active high
   input wire logic sclCtrlOut, // Clock level
   input wire logic sclCtrlOe, // Clock pull
   input wire logic sdaCtrlOut, // Data level
   input wire logic sdaCtrlOe, // Data pull
   input wire logic sdaDevOut, // Target level
   input wire logic sdaDevOe, // Target pull
   input wire logic scl, // Clock wire
   input wire logic sda // Data wire
);
   logic [7:0] lowCnt_reg;
   logic [7:0] perCnt_reg;
   logic sclPrev_reg;
   // Low time, saturating so long stalls never wrap
   always_ff @(posedge clk) begin
      if (sys_rst || scl) begin
         lowCnt_reg <= 8'h00;
      end else if (lowCnt_reg != 8'hff) begin
         lowCnt_reg <= lowCnt_reg + 8'h01;
      end
   end
   // Cycles since last fall; starts full so the first fall passes
   always_ff @(posedge clk) begin
      sclPrev_reg <= sys_rst | scl;
      if (sys_rst) begin
         perCnt_reg <= 8'hff;
      end else if (sclPrev_reg && !scl) begin
         perCnt_reg <= 8'h01;
      end else if (perCnt_reg != 8'hff) begin
         perCnt_reg <= perCnt_reg + 8'h01;
      end
   end
   sequence s_startHeld;
      scl [*6];
   endsequence
   sequence s_ackHeld;
      sdaDevOe [*8];
   endsequence
   property p_ctrlOd;
      @(posedge clk) disable iff (sys_rst) !sclCtrlOut && !sdaCtrlOut;
   endproperty
   property p_devOd;
      @(posedge linkClk) disable iff (sys_rst) !sdaDevOut;
   endproperty
   property p_idle;
      @(posedge clk) disable iff (sys_rst) $fell(sys_rst) |-> scl && sda;
   endproperty
   property p_lowTime;
      @(posedge clk) disable iff (sys_rst) $rose(scl) |-> lowCnt_reg >= 8'h0d;
   endproperty
   property p_period;
      @(posedge clk) disable iff (sys_rst) (sclPrev_reg && !scl) |-> perCnt_reg >= 8'h19;
   endproperty
   property p_startHold;
      @(posedge clk) disable iff (sys_rst) ($fell(sda) && scl) |-> s_startHeld;
   endproperty
   property p_stopSetup;
      @(posedge clk) disable iff (sys_rst) ($rose(sda) && scl) |-> $past(scl, 6);
   endproperty
   property p_devEdge;
      @(posedge linkClk) disable iff (sys_rst) $changed(sdaDevOe) |-> !scl;
   endproperty
   property p_ackHeld;
      @(posedge linkClk) disable iff (sys_rst) ($rose(scl) && sdaDevOe) |-> s_ackHeld;
   endproperty
   a_ctrlOd: assert property (p_ctrlOd) else $error("ctrl drives high");
   a_devOd: assert property (p_devOd) else $error("target drives high");
   a_idle: assert property (p_idle) else $error("bus busy after reset");
   a_lowTime: assert property (p_lowTime) else $error("clock low too short");
   a_period: assert property (p_period) else $error("clock too fast");
   a_startHold: assert property (p_startHold) else $error("start hold short");
   a_stopSetup: assert property (p_stopSetup) else $error("stop setup short");
   a_devEdge: assert property (p_devEdge) else $error("target moved in high");
   a_ackHeld: assert property (p_ackHeld) else $error("target let go early");
endmodule // acci2c_asserts

// ### verif/accel_i2c_target_port_tb.sv
// Bench joining controller and target over the two-wire link.
// Holds the register file; expectations come from the bytes written and from the initial fill.
`timescale 1ns/10ps
module accel_i2c_target_port_tb;
   import acci2c_pkg::*;
   logic clk, linkClk, sys_rst, cmdValid, cmdRead, cmdSplitStop, fastMode, cmdReady, wrTake;
   logic rdValid, done, nackErr, chipSelect, busAddressStrap, regWrite, regRead;
   logic busActive, act;
   logic [6:0] cmdDevAddr;
   logic [7:0] cmdRegAddr, cmdLen, wrData, rdData, regPtr, regRdData, regAddr, regWrData;
   logic [7:0] mem [256];
   logic [7:0] sniff, lastAddr;
   logic [7:0] wq [$];
   logic [7:0] rq [$];
   int failures, checks, nBit, nRead;
   acci2c_if bus ();
   acci2c_ctrl acci2c_ctrl_i (.clk(clk), .sys_rst(sys_rst), .clkEn(1'b1), .fastMode(fastMode),
      .cmdValid(cmdValid), .cmdReady(cmdReady), .cmdRead(cmdRead), .cmdSplitStop(cmdSplitStop),
      .cmdDevAddr(cmdDevAddr), .cmdRegAddr(cmdRegAddr), .cmdLen(cmdLen), .wrData(wrData),
      .wrTake(wrTake), .rdData(rdData), .rdValid(rdValid), .done(done), .nackErr(nackErr),
      .bus(bus.ctrl));
   acci2c_target acci2c_target_i (.linkClk(linkClk), .sys_rst(sys_rst), .clkEn(1'b1),
      .bus(bus.dev), .chipSelect(chipSelect), .busAddressStrap(busAddressStrap),
      .regPtr(regPtr), .regRdData(regRdData), .regWrite(regWrite), .regRead(regRead),
      .regAddr(regAddr), .regWrData(regWrData), .busActive(busActive));
   acci2c_asserts acci2c_asserts_i (.clk(clk), .linkClk(linkClk), .sys_rst(sys_rst),
      .sclCtrlOut(bus.sclCtrlOut), .sclCtrlOe(bus.sclCtrlOe), .sdaCtrlOut(bus.sdaCtrlOut),
      .sdaCtrlOe(bus.sdaCtrlOe), .sdaDevOut(bus.sdaDevOut), .sdaDevOe(bus.sdaDevOe),
      .scl(bus.scl), .sda(bus.sda));
   // Register file; read side combinational as the target expects
   assign regRdData = mem[regPtr];
   always @(posedge linkClk) if (regWrite) mem[regAddr] <= regWrData;
   // Fetches and activity seen by the target, cleared per command
   always @(posedge linkClk) begin
      if (regRead === 1'b1) nRead++;
      if (busActive === 1'b1) act = 1'b1;
   end
   // Feed and collect bytes just after the edge, never on it
   always @(posedge clk) begin
      #1;
      if (wrTake === 1'b1) void'(wq.pop_front());
      wrData = (wq.size() > 0) ? wq[0] : 8'h00;
      if (rdValid === 1'b1) rq.push_back(rdData);
   end
   // Address byte on the wire after the latest start
   always @(negedge bus.sda) if (bus.scl === 1'b1) nBit = 0;
   always @(posedge bus.scl) begin
      if (nBit < 8) sniff = {sniff[6:0], bus.sda};
      nBit = nBit + 1;
      if (nBit == 8) lastAddr = sniff;
   end
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // Link clock free running, phase unrelated
   initial begin
      linkClk = 1'b0;
      #13;
      forever #32 linkClk = ~linkClk;
   end
   task automatic summarize();
      if (failures == 0 && checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   // One whole command: request held until taken, then bounded wait for done
   task automatic xfer(input logic rd, split, fast, input logic [6:0] dev,
                       input logic [7:0] ra, len);
      int n;
      n = 0;
      rq.delete();
      {act, nRead} = '0;
      {cmdRead, cmdSplitStop, fastMode} = {rd, split, fast};
      {cmdDevAddr, cmdRegAddr, cmdLen} = {dev, ra, len};
      cmdValid = 1'b1;
      while (cmdReady !== 1'b1) begin @(posedge clk); #1; end
      @(posedge clk);
      #1;
      cmdValid = 1'b0;
      while (done !== 1'b1 && n < 20000) begin @(posedge clk); #1; n++; end
      chk("done", 8'h01, {7'h00, done});
      chk("idle", 8'h00, {7'h00, busActive});
   endtask
   // Watchdog, far beyond the frames below
   initial begin
      repeat (90000) @(posedge clk);
      failures++;
      summarize();
   end
   initial begin
      {sys_rst, cmdValid, cmdRead, cmdSplitStop, fastMode, chipSelect, busAddressStrap} = 7'h43;
      {cmdDevAddr, cmdRegAddr, cmdLen, wrData} = '0;
      {failures, checks, nBit} = {32'd0, 32'd0, 32'd9};
      foreach (mem[i]) mem[i] = 8'(i) ^ 8'hc3;
      repeat (6) @(posedge clk);
      #1;
      sys_rst = 1'b0;
      repeat (10) @(posedge clk);
      #1;
      // Fast burst write, then burst read back with repeated start
      wq = '{8'h5a, 8'h6b, 8'h7c};
      xfer(0, 0, 1, ADDR_STRAP_HIGH, 8'h10, 8'h03);
      chk("addr byte", 8'h3a, lastAddr);
      chk("nack", 8'h00, {7'h00, nackErr});
      chk("active", 8'h01, {7'h00, act});
      for (int i = 0; i < 3; i++) chk("reg", 8'(8'h5a + 8'h11 * i), mem[8'h10 + i]);
      xfer(1, 0, 1, ADDR_STRAP_HIGH, 8'h10, 8'h03);
      chk("addr byte", 8'h3b, lastAddr);
      chk("count", 8'h03, 8'(rq.size()));
      chk("fetches", 8'h03, 8'(nRead));
      for (int i = 0; i < 3; i++) chk("burst", 8'(8'h5a + 8'h11 * i), rq[i]);
      chk("ptr", 8'h13, regPtr);
      // Single read with stop then start
      xfer(1, 1, 1, ADDR_STRAP_HIGH, 8'h11, 8'h01);
      chk("single", 8'h6b, rq[0]);
      // Pointer wraps past the top register
      wq = '{8'h81, 8'h92};
      xfer(0, 0, 1, ADDR_STRAP_HIGH, 8'hff, 8'h02);
      chk("wrap", 8'h92, mem[0]);
      chk("ptr", 8'h01, regPtr);
      // Other address ignored, register untouched
      wq = '{8'hee};
      xfer(0, 0, 1, ADDR_STRAP_LOW, 8'h20, 8'h01);
      chk("foreign", 8'h01, {7'h00, nackErr});
      chk("untouched", 8'he3, mem[8'h20]);
      // Strap low at standard rate, then old address tried at fast rate
      busAddressStrap = 1'b0;
      repeat (4) @(posedge clk);
      #1;
      wq = '{8'h47};
      xfer(0, 0, 0, ADDR_STRAP_LOW, 8'h20, 8'h01);
      chk("addr byte", 8'ha6, lastAddr);
      xfer(1, 0, 0, ADDR_STRAP_LOW, 8'h20, 8'h01);
      chk("addr byte", 8'ha7, lastAddr);
      chk("std read", 8'h47, rq[0]);
      xfer(1, 0, 1, ADDR_STRAP_HIGH, 8'h20, 8'h01);
      chk("old addr", 8'h01, {7'h00, nackErr});
      // Deselected port stays silent
      chipSelect = 1'b0;
      repeat (4) @(posedge clk);
      #1;
      xfer(0, 0, 1, ADDR_STRAP_LOW, 8'h30, 8'h01);
      chk("deselect", 8'h01, {7'h00, nackErr});
      chk("active", 8'h00, {7'h00, act});
      summarize();
   end
endmodule // accel_i2c_target_port_tb
